// ===== verilog/spirq_map.svh
// Register offsets, field positions, reset values and timing counts of the
// serial port interrupt logic. Definitions only; included by bare name.
//
// Functional notes
// - Five outputs: rx service, tx service, overrun, timeout, and combined.
// - A mask bit of one enables its request; zero suppresses it.
// - Raw and masked status are readable in separate registers.
// - Rx service request high while rx FIFO holds four or more entries.
// - Tx service request high while tx FIFO holds four or fewer entries.
// - Tx service request ignores the port enable signal.
// - Overrun asserts when a frame completes while rx FIFO is full.
// - On overrun the shift register takes the frame; FIFO stays unchanged.
// - Timeout asserts when rx FIFO non-empty and idle for 32 bit times.
// - Timeout drops when rx FIFO empties or new serial input arrives.
// - Writing one to the timeout clear bit is overridden while the idle timer stays expired, so the timeout request stays set.
// - Combined request is the OR of the four masked requests.
// - FIFO dataflow requests stay separate outputs from status requests.
`ifndef SPIRQ_MAP_SVH
`define SPIRQ_MAP_SVH

// Byte offsets of the registers
`define SPIRQ_MASK_OFS 12'h014
`define SPIRQ_RAW_OFS 12'h018
`define SPIRQ_MIS_OFS 12'h01C
`define SPIRQ_CLR_OFS 12'h020

// Field positions shared by mask, raw, masked and clear registers
`define SPIRQ_BIT_OVR 0
`define SPIRQ_BIT_TMO 1
`define SPIRQ_BIT_RX 2
`define SPIRQ_BIT_TX 3

// Reset values and levels
`define SPIRQ_MASK_RST 4'h0
`define SPIRQ_RX_LEVEL 4
`define SPIRQ_TX_LEVEL 4
`define SPIRQ_IDLE_BITS 32

`endif

// ===== verilog/spirq_pkg.sv
// Types of the serial port interrupt logic.
// Assumes the map header supplies the numeric constants.
package spirq_pkg;
  // One bit per source: tx, rx, timeout, overrun
  typedef struct packed {
    logic tx;
    logic rx;
    logic tmo;
    logic ovr;
  } spirq_src_type;

  // Data-phase states of the bus slave
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } spirq_bus_state_type;

  // Latched address phase
  typedef struct packed {
    logic [11:0] addr;
    logic write;
  } spirq_aphase_type;
endpackage

// ===== verilog/spirq_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes rst_n is already synchronous to clk.
module spirq_sync (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset
  input wire logic d_in, // Asynchronous level
  output logic q_out // Synchronised level
);
  logic meta_reg;

  // First stage read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // spirq_sync

// ===== verilog/spirq_idle.sv
// Idle timer: counts bit ticks since the last serial input change.
// Assumes bit_tick is a one-cycle pulse per bit time from the port.
`include "spirq_map.svh"
module spirq_idle #(
  parameter int IDLE_BITS = `SPIRQ_IDLE_BITS
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset
  input wire logic bit_tick, // One pulse per bit time
  input wire logic activity, // Serial input changed
  output logic idle_done // Idle for IDLE_BITS bit times
);
  localparam int CW = $clog2(IDLE_BITS + 1);
  localparam logic [CW-1:0] LIMIT = CW'(IDLE_BITS);
  logic [CW-1:0] cnt_reg;

  // Count saturates; any activity restarts the period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (activity)
      cnt_reg <= '0;
    else if (bit_tick && cnt_reg != LIMIT)
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign idle_done = (cnt_reg == LIMIT);
endmodule // spirq_idle

// ===== verilog/spirq_top.sv
// Interrupt logic of a synchronous serial port with an AHB-Lite slave.
// Assumes FIFO levels, frame events and bit ticks come from the port core.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`include "spirq_map.svh"
module spirq_top #(
  parameter int FIFO_DEPTH = 8,
  parameter int LVL_W = 4
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic [LVL_W-1:0] rx_level, // Rx FIFO fill count
  input wire logic [LVL_W-1:0] tx_level, // Tx FIFO fill count
  input wire logic rx_frame_done, // Frame completed, one pulse
  input wire logic bit_tick, // One pulse per bit time
  input wire logic serial_rx_in, // Serial receive pin
  output logic rx_shift_load, // Shift register takes frame
  output logic rx_fifo_push, // Frame goes into rx FIFO
  output logic rx_service_irq, // Masked rx service
  output logic tx_service_irq, // Masked tx service
  output logic rx_overrun_irq, // Masked overrun
  output logic rx_timeout_irq, // Masked timeout
  output logic combined_irq // OR of masked requests
);
  localparam logic [LVL_W-1:0] RX_LVL = LVL_W'(`SPIRQ_RX_LEVEL);
  localparam logic [LVL_W-1:0] TX_LVL = LVL_W'(`SPIRQ_TX_LEVEL);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(FIFO_DEPTH);

  // Whole state of the module apart from the reset synchroniser flops and the sub-modules
  typedef struct packed {
    spirq_pkg::spirq_bus_state_type bst;
    spirq_pkg::spirq_aphase_type ap;
    logic [3:0] mask;
    logic ovr;
    logic tmo;
    logic rxd_last;
    logic [31:0] rdata;
    logic [3:0] irq;
    logic comb;
    logic shift_load;
    logic push;
  } spirq_state_type;

  spirq_state_type s_reg;
  spirq_state_type s_next;
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rxd_sync;
  logic idle_done;
  logic activity;
  logic rx_nonempty;
  logic rx_full;
  spirq_pkg::spirq_src_type raw;
  logic [3:0] masked;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Serial pin is asynchronous to the core clock
  spirq_sync u_rxd_sync (
    .clk(core_clk),
    .rst_n(rst_sync_reg),
    .d_in(serial_rx_in),
    .q_out(rxd_sync)
  );

  // New data on the line counts as activity
  assign activity = rxd_sync ^ s_reg.rxd_last;

  spirq_idle #(
    .IDLE_BITS(`SPIRQ_IDLE_BITS)
  ) u_idle (
    .clk(core_clk),
    .rst_n(rst_sync_reg),
    .bit_tick(bit_tick),
    .activity(activity),
    .idle_done(idle_done)
  );

  // Level-driven sources; tx ignores the port enable on purpose
  assign rx_nonempty = (rx_level != '0);
  assign rx_full = (rx_level >= FULL_LVL);
  always_comb
  begin
    raw.rx = (rx_level >= RX_LVL);
    raw.tx = (tx_level <= TX_LVL);
    raw.ovr = s_reg.ovr;
    raw.tmo = s_reg.tmo;
  end
  assign masked = raw & s_reg.mask;

  // Next-state logic: bus slave, sticky sources, registered outputs
  always_comb
  begin
    logic take;
    logic wr_mask;
    logic wr_clr;
    take = 1'b0;
    wr_mask = 1'b0;
    wr_clr = 1'b0;
    s_next = s_reg;
    s_next.rxd_last = rxd_sync;
    s_next.shift_load = rx_frame_done;
    s_next.push = rx_frame_done && !rx_full;
    // Data phase completes in the cycle after the address phase
    unique case (s_reg.bst)
      spirq_pkg::ST_IDLE:
        ;
      spirq_pkg::ST_READ:
        ;
      spirq_pkg::ST_WRITE:
      begin
        wr_mask = (s_reg.ap.addr == `SPIRQ_MASK_OFS);
        wr_clr = (s_reg.ap.addr == `SPIRQ_CLR_OFS);
      end
    endcase
    if (wr_mask)
      s_next.mask = hwdata[3:0];
    // Events win over a clear in the same cycle
    if (wr_clr && hwdata[`SPIRQ_BIT_OVR])
      s_next.ovr = 1'b0;
    if (rx_frame_done && rx_full)
      s_next.ovr = 1'b1;
    if (wr_clr && hwdata[`SPIRQ_BIT_TMO])
      s_next.tmo = 1'b0;
    if (!rx_nonempty || activity)
      s_next.tmo = 1'b0;
    else if (idle_done)
      s_next.tmo = 1'b1;
    // New address phase
    take = hsel && hready && htrans[1];
    s_next.bst = !take ? spirq_pkg::ST_IDLE
               : hwrite ? spirq_pkg::ST_WRITE : spirq_pkg::ST_READ;
    s_next.ap.addr = haddr[11:0];
    s_next.ap.write = hwrite;
    // Read data registered at the address phase; unmapped reads give zero
    s_next.rdata = 32'h0000_0000;
    if (take && !hwrite)
    begin
      unique case (haddr[11:0])
        `SPIRQ_MASK_OFS: s_next.rdata = {28'h000_0000, s_reg.mask};
        `SPIRQ_RAW_OFS: s_next.rdata = {28'h000_0000, raw};
        `SPIRQ_MIS_OFS: s_next.rdata = {28'h000_0000, masked};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    // Separate outputs per source plus combined
    s_next.irq = masked;
    s_next.comb = |masked;
  end

  // Single state register; mask cleared at reset
  always_ff @(posedge core_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      s_reg <= '0;
      s_reg.mask <= `SPIRQ_MASK_RST;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from flops; hreadyout and hresp tied to constants
  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0;
  assign rx_shift_load = s_reg.shift_load;
  assign rx_fifo_push = s_reg.push;
  assign rx_service_irq = s_reg.irq[`SPIRQ_BIT_RX];
  assign tx_service_irq = s_reg.irq[`SPIRQ_BIT_TX];
  assign rx_overrun_irq = s_reg.irq[`SPIRQ_BIT_OVR];
  assign rx_timeout_irq = s_reg.irq[`SPIRQ_BIT_TMO];
  assign combined_irq = s_reg.comb;

  // Sequence: a frame completes while the FIFO is full
  sequence ovr_event_s;
    rx_frame_done && rx_full;
  endsequence

  a_ovr_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    ovr_event_s |=> s_reg.ovr) else $error("Overrun not latched");

  a_ovr_holds: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    s_reg.ovr && !(s_reg.bst == spirq_pkg::ST_WRITE && s_reg.ap.addr == `SPIRQ_CLR_OFS)
    |=> s_reg.ovr) else $error("Overrun dropped without clear");

  a_no_push_full: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    ovr_event_s |=> !rx_fifo_push && rx_shift_load) else $error("Full FIFO written");

  a_rx_level: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    raw.rx == (rx_level >= RX_LVL)) else $error("Rx service level wrong");

  a_tx_level: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    raw.tx == (tx_level <= TX_LVL)) else $error("Tx service level wrong");

  a_mask_gates: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    ##1 rx_service_irq == $past(raw.rx && s_reg.mask[`SPIRQ_BIT_RX]))
    else $error("Rx output not gated by mask");

  a_comb_or: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    combined_irq == (rx_service_irq || tx_service_irq || rx_overrun_irq || rx_timeout_irq))
    else $error("Combined is not OR");

  a_tmo_empty: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    !rx_nonempty |=> !s_reg.tmo) else $error("Timeout with empty FIFO");

  a_tmo_clear: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
    s_reg.bst == spirq_pkg::ST_WRITE && s_reg.ap.addr == `SPIRQ_CLR_OFS
    && hwdata[`SPIRQ_BIT_TMO] && !idle_done |=> !s_reg.tmo)
    else $error("Timeout not cleared");
endmodule // spirq_top

// ===== verification/spirq_port_model.sv
// Stand-in for the port core: bit ticks, frame pulses and the receive pin.
// Assumes commands are changed by non-blocking assignment after rising edges.
module spirq_port_model (
  input wire logic clk, // Core clock
  input wire logic tick_en, // Run bit ticks
  input wire logic frame_go, // Request one frame
  input wire logic line_flip, // Toggle receive pin
  output logic bit_tick, // One pulse per bit time
  output logic rx_frame_done, // Frame finished pulse
  output logic serial_rx_in // Receive pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Known levels from time zero; the pin idles high
  initial
  begin
    bit_tick = 1'b0;
    rx_frame_done = 1'b0;
    serial_rx_in = 1'b1;
  end

  // Tick every second cycle so a bit time is two core cycles
  always @(posedge clk)
  begin
    bit_tick <= tick_en & ~bit_tick;
    rx_frame_done <= frame_go;
    serial_rx_in <= serial_rx_in ^ line_flip;
  end
endmodule // spirq_port_model

// ===== verification/spirq_top_tb.sv
// Self-checking bench of the serial port interrupt logic.
// Assumes zero wait states on reads and the register map of the header.
`include "spirq_map.svh"
module spirq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] rx_level = 4'h0;
  logic [3:0] tx_level = 4'h0;
  logic tick_en = 1'b0;
  logic frame_go = 1'b0;
  logic line_flip = 1'b0;
  logic bit_tick, rx_frame_done, serial_rx_in, rx_shift_load, rx_fifo_push;
  logic rx_service_irq, tx_service_irq, rx_overrun_irq, rx_timeout_irq, combined_irq;
  logic [31:0] rd_q[$];
  logic [31:0] rd_v;
  logic [3:0] msk, r, t, s;
  logic ld, pu;
  event rd_ev;
  int mismatches = 0;
  int n_tests = 0;
  int i, n;

  always #10 core_clk = ~core_clk;

  spirq_top #(.FIFO_DEPTH(8), .LVL_W(4)) spirq_top_i (.core_clk(core_clk),
    .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_level(rx_level), .tx_level(tx_level),
    .rx_frame_done(rx_frame_done), .bit_tick(bit_tick), .serial_rx_in(serial_rx_in),
    .rx_shift_load(rx_shift_load), .rx_fifo_push(rx_fifo_push),
    .rx_service_irq(rx_service_irq), .tx_service_irq(tx_service_irq),
    .rx_overrun_irq(rx_overrun_irq), .rx_timeout_irq(rx_timeout_irq),
    .combined_irq(combined_irq));

  spirq_port_model spirq_port_model_i (.clk(core_clk), .tick_en(tick_en),
    .frame_go(frame_go), .line_flip(line_flip), .bit_tick(bit_tick),
    .rx_frame_done(rx_frame_done), .serial_rx_in(serial_rx_in));

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask

  task test_done;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Read monitor: oldest expectation against each captured read
  initial
  forever
  begin
    @(rd_ev);
    cmp("hrdata", rd_q.pop_front(), rd_v);
  end

  // One single transfer; waits on ready in both phases
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    cmp("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    if (!w)
    begin
      rd_v = hrdata;
      ->rd_ev;
    end
  endtask

  // Extra idle cycle after each write; a read just after a write would already show the new value
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge core_clk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Outputs sampled off the edge, once the source has had time to pass
  task irq(input logic [3:0] src);
    logic [3:0] e;
    e = src & msk;
    repeat (3) @(posedge core_clk);
    #1;
    cmp("irq", {27'h000_0000, |e, e}, {27'h000_0000, combined_irq, tx_service_irq,
      rx_service_irq, rx_timeout_irq, rx_overrun_irq});
    @(posedge core_clk);
  endtask

  task frame;
    frame_go <= 1'b1;
    @(posedge core_clk);
    frame_go <= 1'b0;
    ld = 1'b0;
    pu = 1'b0;
    repeat (4)
    begin
      @(posedge core_clk);
      #1;
      ld = ld | rx_shift_load;
      pu = pu | rx_fifo_push;
    end
    @(posedge core_clk);
  endtask

  // Bounded wait for the timeout request, counting core cycles
  task wait_tmo;
    n = 0;
    while (rx_timeout_irq !== 1'b1 && n < 150)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(98804));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    msk = 4'h0;
    rd(`SPIRQ_MASK_OFS, 32'h0000_0000);
    irq(4'h8);
    rd(12'h040, 32'h0000_0000);
    msk = 4'hF;
    wr(`SPIRQ_MASK_OFS, 32'h0000_000F);
    rd(`SPIRQ_MASK_OFS, 32'h0000_000F);
    for (i = 0; i < 8; i++)
    begin
      r = 4'($urandom_range(8));
      t = 4'($urandom_range(8));
      rx_level <= r;
      tx_level <= t;
      s = {t <= 4'h4, r >= 4'h4, 2'b00};
      irq(s);
      rd(`SPIRQ_RAW_OFS, {28'h000_0000, s});
    end
    // Only rx service enabled; tx stays raw but masked
    rx_level <= 4'h4;
    tx_level <= 4'h0;
    msk = 4'h4;
    wr(`SPIRQ_MASK_OFS, 32'h0000_0004);
    irq(4'hC);
    rd(`SPIRQ_MIS_OFS, 32'h0000_0004);
    rd(`SPIRQ_RAW_OFS, 32'h0000_000C);
    // Overrun with a full FIFO, then latch and clear
    msk = 4'hF;
    wr(`SPIRQ_MASK_OFS, 32'h0000_000F);
    rx_level <= 4'h8;
    tx_level <= 4'h8;
    frame();
    cmp("load", 32'h1, {31'h0, ld});
    cmp("push", 32'h0, {31'h0, pu});
    irq(4'h5);
    repeat (10) @(posedge core_clk);
    irq(4'h5);
    wr(`SPIRQ_CLR_OFS, 32'h0000_0001);
    irq(4'h4);
    rx_level <= 4'h2;
    frame();
    cmp("push", 32'h1, {31'h0, pu});
    irq(4'h0);
    // Idle timeout: 32 ticks at one per two cycles
    tick_en <= 1'b1;
    wait_tmo();
    cmp("idle", 32'h1, {31'h0, n >= 60 && n <= 72});
    irq(4'h2);
    line_flip <= 1'b1;
    @(posedge core_clk);
    line_flip <= 1'b0;
    // Pin change needs two sync flops plus the flag and output stages
    repeat (2) @(posedge core_clk);
    irq(4'h0);
    wait_tmo();
    irq(4'h2);
    rx_level <= 4'h0;
    irq(4'h0);
    test_done();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
endmodule // spirq_top_tb
